// >>> hdl/sew_pkg.sv
// Constants and types shared by the serial EEPROM write target
package sew_pkg;

    localparam logic [3:0]  DEV_TYPE_MAIN = 4'ha;
    localparam logic [3:0]  DEV_TYPE_ID   = 4'hb;
    localparam int unsigned DA_TYPE_MSB   = 7;
    localparam int unsigned DA_TYPE_LSB   = 4;
    localparam int unsigned DA_CS_MSB     = 3;
    localparam int unsigned DA_CS_LSB     = 1;
    localparam int unsigned DA_RW_BIT     = 0;
    localparam int unsigned ID_SEL_BIT    = 10;
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned OFS_W         = 7;
    localparam int unsigned PAGE_W        = 9;
    localparam int unsigned PAGE_BYTES    = 128;
    localparam int unsigned NUM_PAGES     = 512;
    localparam int unsigned MEM_BYTES     = PAGE_BYTES * NUM_PAGES;
    localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
    localparam logic [3:0]  ACK_SLOT      = 4'h8;
    localparam logic [15:0] WADDR_RST     = 16'h0000;

    // Write cycle time and system clock rate
    localparam int unsigned TWR_MS        = 3;
    localparam int unsigned SYS_CLK_KHZ   = 100000;
    localparam int unsigned PROG_CYCLES   = TWR_MS * SYS_CLK_KHZ;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_DATA,
        ST_READ
    } sew_state_t;

    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wp;
        logic       lock;
        logic [2:0] cs;
    } sew_pins_t;

    localparam sew_pins_t PINS_RST = '{scl: 1'b1, sda: 1'b1, wp: 1'b0, lock: 1'b0, cs: 3'h0};

endpackage

// >>> hdl/sew_target.sv
// Serial EEPROM write target: bus engine, page buffer, array and timer
`timescale 1ns/1ns
module sew_target #(
    parameter int unsigned PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        scl_clk,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        chip_select_strap_high,
    input  wire logic        chip_select_strap_mid,
    input  wire logic        chip_select_strap_low,
    input  wire logic        write_protect,
    input  wire logic        id_page_locked,
    input  wire logic [15:0] peek_addr,
    input  wire logic        peek_id,
    output logic [7:0]       peek_data,
    output logic             standby,
    output logic             prog_busy
);

    // Link side: bits captured on the serial clock
    logic lk_rst_meta;
    logic lk_rst;
    logic lk_bit;
    logic lk_tgl;
    logic next_lk_bit;
    logic next_lk_tgl;

    always_comb begin
        next_lk_bit = sda_i;
        next_lk_tgl = ~lk_tgl;
        if (lk_rst) begin
            next_lk_bit = 1'b0;
            next_lk_tgl = 1'b0;
        end
    end

    always_ff @(posedge scl_clk) begin
        lk_rst_meta <= sys_rst;
        lk_rst      <= lk_rst_meta;
        lk_bit      <= next_lk_bit;
        lk_tgl      <= next_lk_tgl;
    end

    // System side synchronisers
    sew_pkg::sew_pins_t pin_raw;
    sew_pkg::sew_pins_t pin_meta;
    sew_pkg::sew_pins_t pin_s;
    logic               scl_d;
    logic               sda_d;
    logic               tgl_meta;
    logic               tgl_s;
    logic               tgl_d;

    // Floating straps are biased low on the pad, so they compare as zero
    assign pin_raw = '{scl: scl_clk, sda: sda_i, wp: write_protect, lock: id_page_locked,
                       cs: {chip_select_strap_high, chip_select_strap_mid,
                            chip_select_strap_low}};

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_meta <= sew_pkg::PINS_RST;
            pin_s    <= sew_pkg::PINS_RST;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
            tgl_meta <= 1'b0;
            tgl_s    <= 1'b0;
            tgl_d    <= 1'b0;
        end else begin
            pin_meta <= pin_raw;
            pin_s    <= pin_meta;
            scl_d    <= pin_s.scl;
            sda_d    <= pin_s.sda;
            tgl_meta <= lk_tgl;
            tgl_s    <= tgl_meta;
            tgl_d    <= tgl_s;
        end
    end

    // Bus events; the captured bit is stable for a whole clock period
    logic bit_ev;
    logic start_ev;
    logic stop_ev;
    logic scl_fall;

    assign bit_ev   = tgl_s ^ tgl_d;
    assign start_ev = pin_s.scl && scl_d && sda_d && !pin_s.sda;
    assign stop_ev  = pin_s.scl && scl_d && !sda_d && pin_s.sda;
    assign scl_fall = scl_d && !pin_s.scl;

    function automatic logic [3:0] dev_type(input logic [7:0] b);
        dev_type = b[sew_pkg::DA_TYPE_MSB:sew_pkg::DA_TYPE_LSB];
    endfunction

    function automatic logic dev_hit(input logic [7:0] b, input logic [2:0] cs);
        dev_hit = (dev_type(b) == sew_pkg::DEV_TYPE_MAIN || dev_type(b) == sew_pkg::DEV_TYPE_ID)
                  && b[sew_pkg::DA_CS_MSB:sew_pkg::DA_CS_LSB] == cs;
    endfunction

    // Protocol engine and programming timer
    sew_pkg::sew_state_t st;
    sew_pkg::sew_state_t next_st;
    logic [3:0]          bcnt;
    logic [3:0]          next_bcnt;
    logic [7:0]          sh;
    logic [7:0]          next_sh;
    logic [15:0]         waddr;
    logic [15:0]         next_waddr;
    logic                wr_id;
    logic                next_wr_id;
    logic                wr_any;
    logic                next_wr_any;
    logic                ack_go;
    logic                next_ack_go;
    logic                next_sda_oe;
    logic                next_standby;
    logic [127:0]        mask;
    logic [127:0]        next_mask;
    logic                next_busy;
    logic [31:0]         prog_cnt;
    logic [31:0]         next_prog_cnt;
    logic                prog_id;
    logic                next_prog_id;
    logic [8:0]          prog_page;
    logic [8:0]          next_prog_page;
    logic                walk;
    logic                next_walk;
    logic [6:0]          walk_idx;
    logic [6:0]          next_walk_idx;
    logic [7:0]          rx_byte;
    logic                byte_done;
    logic                buf_we;

    always_comb begin
        next_st        = st;
        next_bcnt      = bcnt;
        next_sh        = sh;
        next_waddr     = waddr;
        next_wr_id     = wr_id;
        next_wr_any    = wr_any;
        next_ack_go    = ack_go;
        next_sda_oe    = sda_oe;
        next_mask      = mask;
        next_busy      = prog_busy;
        next_prog_cnt  = prog_cnt;
        next_prog_id   = prog_id;
        next_prog_page = prog_page;
        next_walk      = walk;
        next_walk_idx  = walk_idx;
        buf_we         = 1'b0;
        rx_byte        = {sh[6:0], lk_bit};
        byte_done      = bit_ev && bcnt == sew_pkg::LAST_DATA_BIT;

        if (bit_ev) begin
            if (bcnt == sew_pkg::ACK_SLOT) begin
                next_bcnt = 4'h0;
            end else begin
                next_sh   = rx_byte;
                next_bcnt = bcnt + 4'h1;
            end
        end

        if (byte_done) begin
            next_ack_go = 1'b0;
            case (st)
                sew_pkg::ST_DEVADDR: begin
                    if (dev_hit(rx_byte, pin_s.cs) && !prog_busy) begin
                        next_ack_go = 1'b1;
                        next_wr_id  = dev_type(rx_byte) == sew_pkg::DEV_TYPE_ID;
                        next_wr_any = 1'b0;
                        next_mask   = '0;
                        next_st     = rx_byte[sew_pkg::DA_RW_BIT] ? sew_pkg::ST_READ
                                                                 : sew_pkg::ST_ADDR_HI;
                    end else begin
                        next_st = sew_pkg::ST_IDLE;
                    end
                end
                sew_pkg::ST_ADDR_HI: begin
                    next_ack_go       = 1'b1;
                    next_waddr[15:8]  = rx_byte;
                    next_st           = sew_pkg::ST_ADDR_LO;
                end
                sew_pkg::ST_ADDR_LO: begin
                    next_ack_go      = 1'b1;
                    next_waddr[7:0]  = rx_byte;
                    next_st          = sew_pkg::ST_DATA;
                end
                sew_pkg::ST_DATA: begin
                    // Id page refused when locked or when bit ten is set
                    if (!(wr_id && (pin_s.lock
                                    || waddr[sew_pkg::ID_SEL_BIT]))) begin
                        next_ack_go           = 1'b1;
                        buf_we                = 1'b1;
                        next_mask[waddr[6:0]] = 1'b1;
                        next_wr_any           = 1'b1;
                        next_waddr[6:0]       = waddr[6:0] + 7'h01;
                    end
                end
                default: begin
                    next_ack_go = 1'b0;
                end
            endcase
        end

        // Acknowledge driven only from the clock fall after the eighth bit to the fall after the ninth
        if (scl_fall) begin
            next_sda_oe = bcnt == sew_pkg::ACK_SLOT && ack_go;
        end

        if (prog_busy) begin
            if (prog_cnt == 32'h0) begin
                next_busy = 1'b0;
            end else begin
                next_prog_cnt = prog_cnt - 32'h1;
            end
        end
        if (walk) begin
            next_walk_idx = walk_idx + 7'h01;
            if (walk_idx == 7'(sew_pkg::PAGE_BYTES - 1)) begin
                next_walk = 1'b0;
            end
        end

        if (start_ev) begin
            next_st   = sew_pkg::ST_DEVADDR;
            next_bcnt = 4'h0;
        end
        if (stop_ev) begin
            // Protected main array: the transfer was acknowledged but nothing is programmed
            if (st == sew_pkg::ST_DATA && wr_any && !prog_busy
                && (wr_id || !pin_s.wp)) begin
                next_busy      = 1'b1;
                next_prog_cnt  = PROG_CYCLES - 32'h1;
                next_prog_id   = wr_id;
                next_prog_page = waddr[15:7];
                next_walk      = 1'b1;
                next_walk_idx  = 7'h00;
            end
            next_st   = sew_pkg::ST_IDLE;
            next_bcnt = 4'h0;
        end

        next_standby = next_st == sew_pkg::ST_IDLE && !next_busy;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st        <= sew_pkg::ST_IDLE;
            bcnt      <= 4'h0;
            sh        <= 8'h00;
            waddr     <= sew_pkg::WADDR_RST;
            wr_id     <= 1'b0;
            wr_any    <= 1'b0;
            ack_go    <= 1'b0;
            sda_oe    <= 1'b0;
            sda_o     <= 1'b0;
            standby   <= 1'b1;
            mask      <= '0;
            prog_busy <= 1'b0;
            prog_cnt  <= 32'h0;
            prog_id   <= 1'b0;
            prog_page <= 9'h000;
            walk      <= 1'b0;
            walk_idx  <= 7'h00;
        end else begin
            st        <= next_st;
            bcnt      <= next_bcnt;
            sh        <= next_sh;
            waddr     <= next_waddr;
            wr_id     <= next_wr_id;
            wr_any    <= next_wr_any;
            ack_go    <= next_ack_go;
            sda_oe    <= next_sda_oe;
            sda_o     <= 1'b0;
            standby   <= next_standby;
            mask      <= next_mask;
            prog_busy <= next_busy;
            prog_cnt  <= next_prog_cnt;
            prog_id   <= next_prog_id;
            prog_page <= next_prog_page;
            walk      <= next_walk;
            walk_idx  <= next_walk_idx;
        end
    end

    // Page buffer, main array and id page
    logic [7:0] page_buf [sew_pkg::PAGE_BYTES];
    logic [7:0] main_mem [sew_pkg::MEM_BYTES];
    logic [7:0] id_mem   [sew_pkg::PAGE_BYTES];

    always_ff @(posedge clk_sys) begin
        if (buf_we) begin
            page_buf[waddr[6:0]] <= rx_byte;
        end
        if (walk && mask[walk_idx]) begin
            if (prog_id) begin
                id_mem[walk_idx] <= page_buf[walk_idx];
            end else begin
                main_mem[{prog_page, walk_idx}] <= page_buf[walk_idx];
            end
        end
        if (sys_rst) begin
            peek_data <= 8'h00;
        end else if (peek_id) begin
            peek_data <= id_mem[peek_addr[6:0]];
        end else begin
            peek_data <= main_mem[peek_addr];
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_devaddr_hit;
        byte_done && st == sew_pkg::ST_DEVADDR && dev_hit(rx_byte, pin_s.cs) && !prog_busy;
    endsequence

    sequence s_write_stop;
        stop_ev && st == sew_pkg::ST_DATA && wr_any && !prog_busy;
    endsequence

    // Drive stands from the fall after the eighth bit to the fall after the ninth
    AST_OE_ONLY_NINTH: assert property (sda_oe |-> bcnt == sew_pkg::ACK_SLOT
                                        || bcnt == 4'h0)
        else $error("data line driven outside acknowledge slot");

    AST_OE_RISE_NINTH: assert property ($rose(sda_oe) |-> bcnt == sew_pkg::ACK_SLOT
                                        && ack_go)
        else $error("acknowledge begun outside ninth slot");

    AST_OE_AFTER_FALL: assert property ($changed(sda_oe) |-> $past(scl_fall))
        else $error("data line drive changed without clock fall");

    AST_DEV_ACK: assert property (s_devaddr_hit |=> ack_go
                                  && (st == sew_pkg::ST_ADDR_HI
                                      || st == sew_pkg::ST_READ))
        else $error("matching address not acknowledged");

    AST_MISMATCH_IDLE: assert property (byte_done && st == sew_pkg::ST_DEVADDR
                                        && !dev_hit(rx_byte, pin_s.cs) && !start_ev
                                        |=> !ack_go && st == sew_pkg::ST_IDLE)
        else $error("mismatched address not sent to standby");

    AST_BUSY_NACK: assert property (byte_done && st == sew_pkg::ST_DEVADDR && prog_busy
                                    |=> !ack_go)
        else $error("address acknowledged while programming");

    AST_PAGE_WRAP: assert property (buf_we && !start_ev && !stop_ev
                                    |=> waddr[6:0] == $past(waddr[6:0]) + 7'h01
                                        && waddr[15:7] == $past(waddr[15:7]))
        else $error("page address did not wrap in page");

    AST_ID_LOCK_NACK: assert property (byte_done && st == sew_pkg::ST_DATA && wr_id
                                       && pin_s.lock |=> !ack_go)
        else $error("locked id page data acknowledged");

    AST_WP_NO_PROG: assert property (s_write_stop ##0 (!wr_id && pin_s.wp)
                                     |=> !prog_busy [*3])
        else $error("protected array began programming");

    AST_PROG_START: assert property (s_write_stop ##0 (wr_id || !pin_s.wp)
                                     |=> prog_busy && !standby ##1 prog_busy)
        else $error("write stop did not start programming");

    AST_START_RESETS: assert property (start_ev && !stop_ev
                                       |=> st == sew_pkg::ST_DEVADDR && bcnt == 4'h0)
        else $error("start did not restart address phase");

    AST_STOP_IDLE: assert property (stop_ev |=> st == sew_pkg::ST_IDLE && bcnt == 4'h0)
        else $error("stop did not return to idle");

endmodule

// >>> sim/sew_ctrl_model.sv
// Two-wire bus controller model: serial clock, open-drain data
`timescale 1ns/1ns
module sew_ctrl_model (
    output logic      scl_clk,
    output logic      sda_oe,
    input  wire logic sda
);
    initial begin
        scl_clk = 1'b1;
        sda_oe  = 1'b0;
    end

    // Clock pulses with data released
    task automatic flush(input int n);
        #3;
        repeat (n) begin
            #80 scl_clk = 1'b1;
            #80 scl_clk = 1'b0;
        end
    endtask

    // Data falls while clock high
    task automatic start();
        #7;
        if (scl_clk === 1'b0) begin
            #40 sda_oe = 1'b0;
            #40 scl_clk = 1'b1;
        end
        #40 sda_oe = 1'b1;
        #40 scl_clk = 1'b0;
    endtask

    // Data changes only in clock low
    task automatic bit_out(input logic b, output logic seen);
        #40 sda_oe = ~b;
        #40 scl_clk = 1'b1;
        seen = sda;
        #80 scl_clk = 1'b0;
    endtask

    // Eight bits MSB first, then released ninth slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(b[i], s);
        bit_out(1'b1, s);
        ack = ~s;
    endtask

    // Data rises while clock high; clock then stands high
    task automatic stop();
        #40 sda_oe = 1'b1;
        #40 scl_clk = 1'b1;
        #40 sda_oe = 1'b0;
        #40;
    endtask
endmodule

// >>> sim/sew_target_tb.sv
// Self-checking bench for the serial EEPROM write target
`timescale 1ns/1ns
module sew_target_tb;
    localparam int unsigned PROG = 200;
    logic        clk_sys;
    logic        sys_rst;
    logic        scl_clk;
    logic        ctl_oe;
    logic        sda_o;
    logic        sda_oe;
    logic        sda;
    logic [2:0]  cs;
    logic        write_protect;
    logic        id_page_locked;
    logic [15:0] peek_addr;
    logic        peek_id;
    logic [7:0]  peek_data;
    logic        standby;
    logic        prog_busy;
    int          mismatches;
    int          checked;
    int          seed;
    logic        ack;
    logic [15:0] wa;
    logic [7:0]  d [0:129];

    // Open-drain wire with pull-up
    assign sda = ((sda_oe && !sda_o) || ctl_oe) ? 1'b0 : 1'b1;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    sew_target #(.PROG_CYCLES(PROG)) sew_target_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_clk(scl_clk), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_strap_high(cs[2]),
        .chip_select_strap_mid(cs[1]), .chip_select_strap_low(cs[0]),
        .write_protect(write_protect), .id_page_locked(id_page_locked),
        .peek_addr(peek_addr), .peek_id(peek_id), .peek_data(peek_data),
        .standby(standby), .prog_busy(prog_busy));

    sew_ctrl_model sew_ctrl_model_inst (.scl_clk(scl_clk), .sda_oe(ctl_oe), .sda(sda));

    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        #1;
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        #1;
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] dev_word(input logic [3:0] ty, input logic [2:0] sel);
        return {ty, sel, 1'b0};
    endfunction

    // Page offset reached after n accepted bytes
    function automatic logic [6:0] ofs_after(input logic [6:0] s, input int n);
        return 7'(int'(s) + n);
    endfunction

    task automatic put(input logic [7:0] b, input logic exp_ack);
        sew_ctrl_model_inst.send_byte(b, ack);
        cmp1(ack, exp_ack, "acknowledge");
    endtask

    task automatic head(input logic [7:0] dw, input logic [15:0] a, input logic exp_ack);
        sew_ctrl_model_inst.start();
        put(dw, exp_ack);
        if (exp_ack) begin
            put(a[15:8], 1'b1);
            put(a[7:0], 1'b1);
        end
    endtask

    task automatic pins(input logic [2:0] c, input logic w, input logic l);
        @(posedge clk_sys);
        cs             <= c;
        write_protect  <= w;
        id_page_locked <= l;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic wait_prog(input logic exp_busy);
        repeat (10) @(posedge clk_sys);
        cmp1(prog_busy, exp_busy, "programming cycle");
        for (int i = 0; i < PROG + 20 && prog_busy !== 1'b0; i++) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
        cmp1(standby, 1'b1, "standby after write");
    endtask

    task automatic peek(input logic id, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        peek_addr <= a;
        peek_id   <= id;
        repeat (2) @(posedge clk_sys);
        cmp8(peek_data, exp, "stored byte");
    endtask

    initial begin
        #800_000;
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        seed = 32'h2472;
        mismatches = 0;
        checked = 0;
        sys_rst = 1'b1;
        cs = 3'h0;
        write_protect = 1'b0;
        id_page_locked = 1'b0;
        peek_addr = 16'h0000;
        peek_id = 1'b0;
        repeat (2) @(posedge clk_sys);
        sew_ctrl_model_inst.flush(10);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        cmp1(standby, 1'b1, "standby at power-up");
        cmp1(prog_busy, 1'b0, "idle timer at power-up");
        // Link capture leaves reset only on serial clock edges
        sew_ctrl_model_inst.flush(9);
        // Byte write per strap setting, then wrong select and wrong type
        for (int s = 0; s < 8; s++) begin
            pins(3'(s), 1'b0, 1'b0);
            wa = 16'($random(seed));
            d[0] = 8'($random(seed));
            head(dev_word(sew_pkg::DEV_TYPE_MAIN, 3'(s)), wa, 1'b1);
            put(d[0], 1'b1);
            sew_ctrl_model_inst.stop();
            wait_prog(1'b1);
            peek(1'b0, wa, d[0]);
            head(dev_word(sew_pkg::DEV_TYPE_MAIN, 3'(s) ^ 3'h5), wa, 1'b0);
            sew_ctrl_model_inst.stop();
            head(dev_word(4'hc, 3'(s)), wa, 1'b0);
            sew_ctrl_model_inst.stop();
            cmp1(standby, 1'b1, "standby after mismatch");
        end
        $display("test byte_write done");
        // Polling during programming, then read direction acknowledged
        head(dev_word(sew_pkg::DEV_TYPE_MAIN, cs), wa, 1'b1);
        put(~d[0], 1'b1);
        sew_ctrl_model_inst.stop();
        head(dev_word(sew_pkg::DEV_TYPE_MAIN, cs), wa, 1'b0);
        sew_ctrl_model_inst.stop();
        wait_prog(1'b1);
        sew_ctrl_model_inst.start();
        put(dev_word(sew_pkg::DEV_TYPE_MAIN, cs) | 8'h01, 1'b1);
        cmp1(standby, 1'b0, "active during read");
        sew_ctrl_model_inst.stop();
        repeat (4) @(posedge clk_sys);
        cmp1(standby, 1'b1, "standby after read");
        peek(1'b0, wa, ~d[0]);
        $display("test polling done");
        // Page write of 130 bytes from offset 126 wraps inside the page
        wa = {9'($random(seed)), 7'h7e};
        head(dev_word(sew_pkg::DEV_TYPE_MAIN, cs), wa, 1'b1);
        for (int i = 0; i < 130; i++) begin
            d[i] = 8'($random(seed));
            put(d[i], 1'b1);
        end
        sew_ctrl_model_inst.stop();
        wait_prog(1'b1);
        for (int i = 2; i < 130; i++) begin
            peek(1'b0, {wa[15:7], ofs_after(7'h7e, i)}, d[i]);
        end
        $display("test page_wrap done");
        // Write protect: acknowledged, no cycle, array unchanged
        pins(cs, 1'b1, 1'b0);
        head(dev_word(sew_pkg::DEV_TYPE_MAIN, cs), wa, 1'b1);
        put(~d[128], 1'b1);
        sew_ctrl_model_inst.stop();
        wait_prog(1'b0);
        peek(1'b0, wa, d[128]);
        $display("test protect done");
        // Id page: protect ignored, upper bits ignored, lock and bit ten refuse
        wa = 16'($random(seed)) & 16'hfbff;
        head(dev_word(sew_pkg::DEV_TYPE_ID, cs), wa, 1'b1);
        put(d[5], 1'b1);
        put(d[6], 1'b1);
        sew_ctrl_model_inst.stop();
        wait_prog(1'b1);
        peek(1'b1, {9'h0, wa[6:0]}, d[5]);
        peek(1'b1, {9'h0, ofs_after(wa[6:0], 1)}, d[6]);
        head(dev_word(sew_pkg::DEV_TYPE_ID, cs), wa | 16'h0400, 1'b1);
        put(8'h00, 1'b0);
        sew_ctrl_model_inst.stop();
        pins(cs, 1'b0, 1'b1);
        head(dev_word(sew_pkg::DEV_TYPE_ID, cs), wa, 1'b1);
        put(~d[5], 1'b0);
        sew_ctrl_model_inst.stop();
        repeat (PROG + 20) @(posedge clk_sys);
        peek(1'b1, {9'h0, wa[6:0]}, d[5]);
        $display("test id_page done");
        // Repeated start abandons the first transfer
        pins(cs, 1'b0, 1'b0);
        head(dev_word(sew_pkg::DEV_TYPE_MAIN, cs), {wa[15:7], 7'h00}, 1'b1);
        put(d[9], 1'b1);
        head(dev_word(sew_pkg::DEV_TYPE_MAIN, cs), wa, 1'b1);
        put(d[10], 1'b1);
        sew_ctrl_model_inst.stop();
        wait_prog(1'b1);
        peek(1'b0, wa, d[10]);
        $display("test restart done");
        end_sim();
    end
endmodule
